// ==== core/cluster_pkg.sv ====
// Purpose: Shared constants and types for the programmable logic cluster.
// Assumes: One APB slave, 32-bit words, byte addresses.
// Notes:   Array sizes are fixed by the cluster architecture.
`default_nettype none

package cluster_pkg;

    // Array geometry
    localparam int N_IN     = 36;                 // Routed inputs
    localparam int N_MC     = 18;                 // Macrocells
    localparam int N_PT     = 90;                 // Product terms
    localparam int N_DIRECT = 5;                  // Direct terms per macrocell
    localparam int N_GCK    = 3;                  // Global clocks
    localparam int N_COL    = 2 * N_IN + 2 * N_MC; // Array columns, feedback included
    localparam int MASK_W   = 128;                // Term mask, four words
    localparam int ALLOC_W  = 96;                 // Allocation mask, three words
    localparam int PINS_DEF = 18;                 // Pin-bonded outputs, default
    localparam int PINS_MIN = 12;                 // Pin-bonded outputs, least

    // Roles of the five direct terms of a macrocell
    localparam int PT_XOR = 0;
    localparam int PT_CLK = 1;
    localparam int PT_SET = 2;
    localparam int PT_RST = 3;
    localparam int PT_OE  = 4;

    // APB address layout
    localparam int ADDR_W     = 14;
    localparam int REGION_LSB = 12;
    localparam int IDX_LSB    = 4;
    localparam int IDX_W      = 8;
    localparam int WORD_LSB   = 2;
    localparam logic [1:0]  REGION_CTRL = 2'h0;
    localparam logic [1:0]  REGION_PT   = 2'h1;
    localparam logic [1:0]  REGION_MC   = 2'h2;
    localparam logic [11:0] OFF_CTRL    = 12'h000; // Run control
    localparam logic [11:0] OFF_STATUS  = 12'h004; // Macrocell outputs
    localparam logic [11:0] OFF_OE      = 12'h008; // Output enables

    // Macrocell field encodings
    localparam logic [1:0] MODE_COMB = 2'h0;
    localparam logic [1:0] MODE_D    = 2'h1;
    localparam logic [1:0] MODE_T    = 2'h2;
    localparam logic [1:0] CLK_PT    = 2'h3;  // 0..2 pick a global clock
    localparam logic [1:0] OE_OFF    = 2'h0;
    localparam logic [1:0] OE_ON     = 2'h1;
    localparam logic [1:0] OE_PT     = 2'h2;

    // Macrocell configuration word, bit 0 is mode lsb
    typedef struct packed {
        logic [18:0] rsvd;     // Reads zero
        logic        out_inv;  // Invert cell output
        logic        xor_en;   // XOR first direct term into sum
        logic [1:0]  oe_sel;   // Output enable source
        logic        gsr_en;   // Obey global set/reset
        logic        rst_en;   // Term-driven reset
        logic        set_en;   // Term-driven set
        logic        clk_inv;  // Clock polarity
        logic [1:0]  clk_sel;  // Clock source
        logic        preload;  // Power-up and GLOBAL_SET_RESET_LINE value
        logic [1:0]  mode;     // Comb, D or T
    } mc_cfg_s;

endpackage

`default_nettype wire

// ==== core/logic_cluster.sv ====
// Purpose: One sum-of-products logic cluster with 18 macrocells, APB configured.
// Assumes: Pin-side inputs are asynchronous to pclk and are synchronised here.
// Notes:   Macrocell clocks are emulated as edges sampled on pclk, so an
//          external clock must run well below pclk / 4 to be seen.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - 36 inputs, true and complement, form 90 terms
// - 18 macrocells, each combinational or registered
// - Any number of terms, up to 90, per macrocell
// - Local feedback into array, except smallest member
// - Five direct terms: data or control inputs
// - Register is D, T or bypassed
// - Independent set and reset, regardless of clock
// - Power-up loads preload value, default zero
// - Clock from three globals or term clock
// - Global clocks usable in either polarity
// - Global set/reset forces user-defined state
// - Outputs to matrix, outputs and enables to pins
// - Twelve to eighteen outputs reach pin cells
module logic_cluster #(
    parameter int PIN_COUNT    = cluster_pkg::PINS_DEF, // Bonded outputs, 12..18
    parameter bit HAS_LOCAL_FB = 1'b1                   // Clear on smallest member
) (
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic [cluster_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [31:0]                      pwdata,
    output var  logic [31:0]                      prdata,
    output var  logic                             pready,
    output var  logic                             pslverr,
    input  wire logic [cluster_pkg::N_IN-1:0]     routed_in,
    input  wire logic [cluster_pkg::N_GCK-1:0]    global_clock_pin,
    input  wire logic                             global_set_reset_line,
    output var  logic [cluster_pkg::N_MC-1:0]     mc_out,
    output var  logic [cluster_pkg::N_MC-1:0]     mc_oe,
    output var  logic [PIN_COUNT-1:0]             pin_io_cell_out,
    output var  logic [PIN_COUNT-1:0]             pin_io_cell_oe
);

    localparam int N_IN  = cluster_pkg::N_IN;
    localparam int N_MC  = cluster_pkg::N_MC;
    localparam int N_PT  = cluster_pkg::N_PT;
    localparam int N_DIR = cluster_pkg::N_DIRECT;

    // Everything the cluster remembers lives in one struct, so reset
    // and the next-state copy cover all of it in one place.
    // Whole module state
    typedef struct packed {
        logic                                         run;      // Cells leave preload
        logic                                         pready;
        logic                                         pslverr;
        logic [31:0]                                  prdata;
        logic [N_IN-1:0]                              in_s1;    // Sync stage one
        logic [N_IN-1:0]                              in_s2;    // Sync stage two
        logic [cluster_pkg::N_GCK-1:0]                gck_s1;
        logic [cluster_pkg::N_GCK-1:0]                gck_s2;
        logic                                         gsr_s1;
        logic                                         gsr_s2;
        logic [N_PT-1:0][cluster_pkg::MASK_W-1:0]     pt_mask;  // AND array fuses
        cluster_pkg::mc_cfg_s [N_MC-1:0]              cfg;
        logic [N_MC-1:0][cluster_pkg::ALLOC_W-1:0]    alloc;    // Term allocation
        logic [N_MC-1:0]                              mc_q;     // Storage elements
        logic [N_MC-1:0]                              clk_q;    // Last clock level
        logic [N_MC-1:0]                              out_q;
        logic [N_MC-1:0]                              oe_q;
        logic [PIN_COUNT-1:0]                         pin_out;
        logic [PIN_COUNT-1:0]                         pin_oe;
    } state_s;

    state_s st;                                 // Registered state
    state_s next;                               // Next state

    logic [N_MC-1:0]                 fb;        // Feedback into array
    logic [cluster_pkg::N_COL-1:0]   lits;      // Array column literals
    logic [N_PT-1:0]                 pt;        // Product term values
    logic [N_MC-1:0]                 dval;      // Sum after XOR
    logic [N_MC-1:0]                 clk_src;   // Selected clock level
    logic [N_MC-1:0]                 comb_out;  // Cell value before register
    logic                            setup;     // APB setup phase
    logic                            hit;       // Mapped address
    logic [cluster_pkg::IDX_W-1:0]   idx;       // Term or cell index
    logic [1:0]                      word;      // Word within entry

    // Register map, byte addresses in paddr:
    //   region 0  run control, output status, output enables
    //   region 1  term masks, four words per term, 108 columns used
    //   region 2  cells, word 0 config, words 1 to 3 allocation mask
    //   region 3  unmapped, refused with pslverr
    // Writes to spare mask or allocation bits are dropped, so these
    // bits always read zero and never reach the array.
    // Region of an APB address
    function automatic logic [1:0] region(input logic [cluster_pkg::ADDR_W-1:0] a);
        return a[cluster_pkg::ADDR_W-1:cluster_pkg::REGION_LSB];
    endfunction

    // Whether an address names a register
    function automatic logic mapped(input logic [cluster_pkg::ADDR_W-1:0] a);
        logic [cluster_pkg::IDX_W-1:0] i;
        i = a[cluster_pkg::IDX_LSB +: cluster_pkg::IDX_W];
        // Only three control words exist; the rest of region 0 is refused
        case (region(a))
            cluster_pkg::REGION_CTRL: begin
                return a[11:0] == cluster_pkg::OFF_CTRL || a[11:0] == cluster_pkg::OFF_STATUS
                    || a[11:0] == cluster_pkg::OFF_OE;
            end
            cluster_pkg::REGION_PT: return 32'(i) < N_PT;
            cluster_pkg::REGION_MC: return 32'(i) < N_MC;
            default: return 1'b0;
        endcase
    endfunction

    // Level of the chosen global clock, polarity not yet applied
    function automatic logic gck_pick(input logic [cluster_pkg::N_GCK-1:0] g,
                                      input logic [1:0] sel);
        case (sel)
            2'h0:    return g[0];
            2'h1:    return g[1];
            2'h2:    return g[2];
            // Code 3 is the term clock, picked before this function
            default: return 1'b0;
        endcase
    endfunction

    // Pipeline seen from the pins, counted in pclk edges:
    //   edge 1 and 2  two-flop synchronisers on inputs, clocks, GLOBAL_SET_RESET_LINE
    //   edge 3        combinational cells show a new sum on mc_out
    //   edge 3        registered cells see a clock edge, mc_q updates
    //   edge 4        registered cells show the new value on mc_out
    // Cell clocks are pclk-sampled levels, so a clock pulse shorter
    // than one pclk period can be lost; that was traded for a
    // single clock domain with no gated or derived clocks.
    // Set, reset and GLOBAL_SET_RESET_LINE are also pclk-sampled, which keeps them
    // independent of the cell clock but adds sync latency.
    // All next-state logic
    always_comb begin
        next = st;
        // Pin-side inputs pass two flops before any logic
        // Only the second stage feeds logic, never the first
        next.in_s1  = routed_in;
        next.in_s2  = st.in_s1;
        next.gck_s1 = global_clock_pin;
        next.gck_s2 = st.gck_s1;
        next.gsr_s1 = global_set_reset_line;
        next.gsr_s2 = st.gsr_s1;

        // Feedback stays inside the cluster, no matrix delay
        fb   = HAS_LOCAL_FB ? st.out_q : '0;
        // Column order, lsb first: inputs true, inputs inverted,
        // feedback true, feedback inverted
        lits = {~fb, fb, ~st.in_s2, st.in_s2};

        // An empty mask gives an unused term, read as zero
        for (int p = 0; p < N_PT; p++) begin
            pt[p] = (|st.pt_mask[p][cluster_pkg::N_COL-1:0])
                  & (&(~st.pt_mask[p][cluster_pkg::N_COL-1:0] | lits));
        end

        for (int m = 0; m < N_MC; m++) begin
            // Any subset of all 90 terms may feed the OR
            // Direct terms unused as controls may be summed here too
            // Optional XOR with the cell's first direct term follows
            dval[m] = |(st.alloc[m][N_PT-1:0] & pt);
            dval[m] = dval[m] ^ (st.cfg[m].xor_en & pt[m * N_DIR + cluster_pkg::PT_XOR]);

            // Clock source and polarity per cell
            // Term clock is the cell's second direct term
            if (st.cfg[m].clk_sel == cluster_pkg::CLK_PT) begin
                clk_src[m] = pt[m * N_DIR + cluster_pkg::PT_CLK];
            end else begin
                clk_src[m] = gck_pick(st.gck_s2, st.cfg[m].clk_sel);
            end
            clk_src[m]    = clk_src[m] ^ st.cfg[m].clk_inv;
            next.clk_q[m] = clk_src[m];

            // Storage element, highest priority first
            // Reset beats set so a cell with both active ends at zero;
            // run low holds every register at preload (power-up state)
            if (!st.run) begin
                next.mc_q[m] = st.cfg[m].preload;
            end else if (st.cfg[m].gsr_en && st.gsr_s2) begin
                next.mc_q[m] = st.cfg[m].preload;
            end else if (st.cfg[m].rst_en && pt[m * N_DIR + cluster_pkg::PT_RST]) begin
                next.mc_q[m] = 1'b0;
            end else if (st.cfg[m].set_en && pt[m * N_DIR + cluster_pkg::PT_SET]) begin
                next.mc_q[m] = 1'b1;
            end else if (clk_src[m] && !st.clk_q[m]) begin
                case (st.cfg[m].mode)
                    cluster_pkg::MODE_D: next.mc_q[m] = dval[m];
                    cluster_pkg::MODE_T: next.mc_q[m] = st.mc_q[m] ^ dval[m];
                    default:             next.mc_q[m] = st.mc_q[m];
                endcase
            end

            // Bypass picks the sum itself
            if (st.cfg[m].mode == cluster_pkg::MODE_D || st.cfg[m].mode == cluster_pkg::MODE_T) begin
                comb_out[m] = st.mc_q[m];
            end else begin
                comb_out[m] = dval[m];
            end
            next.out_q[m] = comb_out[m] ^ st.cfg[m].out_inv;

            // Output enable for the pin cell
            case (st.cfg[m].oe_sel)
                cluster_pkg::OE_ON: next.oe_q[m] = 1'b1;
                cluster_pkg::OE_PT: next.oe_q[m] = pt[m * N_DIR + cluster_pkg::PT_OE];
                default:            next.oe_q[m] = 1'b0;
            endcase
        end

        // Only bonded cells reach pin cells
        // Unbonded cells still feed the matrix through mc_out
        next.pin_out = next.out_q[PIN_COUNT-1:0];
        next.pin_oe  = next.oe_q[PIN_COUNT-1:0];

        // APB slave, one wait-free access phase
        // Pready rises in the cycle after setup, for one cycle only
        setup        = psel & ~penable;
        hit          = mapped(paddr);
        idx          = paddr[cluster_pkg::IDX_LSB +: cluster_pkg::IDX_W];
        word         = paddr[cluster_pkg::WORD_LSB +: 2];
        next.pready  = setup;
        next.pslverr = setup & ~hit;
        next.prdata  = '0;

        // Read data is latched in setup so prdata comes from a flop
        // Status and enable words show the registered outputs
        if (setup && !pwrite && hit) begin
            case (region(paddr))
                cluster_pkg::REGION_CTRL: begin
                    if (paddr[11:0] == cluster_pkg::OFF_CTRL) begin
                        next.prdata = 32'(st.run);
                    end else if (paddr[11:0] == cluster_pkg::OFF_STATUS) begin
                        next.prdata = 32'(st.out_q);
                    end else begin
                        next.prdata = 32'(st.oe_q);
                    end
                end
                cluster_pkg::REGION_PT: next.prdata = st.pt_mask[idx][{word, 5'h00} +: 32];
                default: begin
                    if (word == 2'h0) begin
                        next.prdata = st.cfg[idx];
                    end else begin
                        next.prdata = st.alloc[idx][{word - 2'h1, 5'h00} +: 32];
                    end
                end
            endcase
        end

        // Writes land at the completing edge only
        if (psel && penable && st.pready && pwrite && hit) begin
            case (region(paddr))
                cluster_pkg::REGION_CTRL: begin
                    // Status words are read-only
                    if (paddr[11:0] == cluster_pkg::OFF_CTRL) begin
                        next.run = pwdata[0];
                    end
                end
                cluster_pkg::REGION_PT: begin
                    // Spare bits above the used columns are forced to zero
                    next.pt_mask[idx][{word, 5'h00} +: 32] = pwdata;
                    next.pt_mask[idx][cluster_pkg::MASK_W-1:cluster_pkg::N_COL] = '0;
                end
                default: begin
                    if (word == 2'h0) begin
                        next.cfg[idx]      = cluster_pkg::mc_cfg_s'(pwdata);
                        next.cfg[idx].rsvd = '0;
                    end else begin
                        next.alloc[idx][{word - 2'h1, 5'h00} +: 32] = pwdata;
                        next.alloc[idx][cluster_pkg::ALLOC_W-1:N_PT] = '0;
                    end
                end
            endcase
        end
    end

    // Single state register; reset clears config, so preload defaults to zero
    // Reset branch loads constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next;
        end
    end

    // Outputs straight from flops
    // Pin copies are taken from next, so they never lag mc_out
    assign prdata          = st.prdata;
    assign pready          = st.pready;
    assign pslverr         = st.pslverr;
    assign mc_out          = st.out_q;
    assign mc_oe           = st.oe_q;
    assign pin_io_cell_out = st.pin_out;
    assign pin_io_cell_oe  = st.pin_oe;

endmodule // logic_cluster

`default_nettype wire

// ==== testbench/logic_cluster_chk.sv ====
// Purpose: Port-level checks of the logic cluster, APB side and outputs.
// Assumes: Single pclk domain, presetn async active low.
// Notes:   Pin output copies are judged only while mc_out holds still, pin enable copies only while mc_oe holds still.
`timescale 1ns/1ps
`default_nettype none
module logic_cluster_chk #(
    parameter int PIN_COUNT = 18 // Bonded outputs, as in the design
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic [13:0]          paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [17:0]          mc_out,
    input wire logic [17:0]          mc_oe,
    input wire logic [PIN_COUNT-1:0] pin_io_cell_out,
    input wire logic [PIN_COUNT-1:0] pin_io_cell_oe
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside access");
    a_unmapped_err: assert property (psel && !penable && paddr[13:12] == 2'h3 |=> pslverr)
        else $error("unmapped access not refused");
    a_ctrl_no_err: assert property (psel && !penable && paddr == 14'h0 |=> !pslverr)
        else $error("mapped access refused");
    a_pin_out_copy: assert property ($stable(mc_out) |-> pin_io_cell_out == mc_out[PIN_COUNT-1:0])
        else $error("pin output differs from cell output");
    a_pin_oe_copy: assert property ($stable(mc_oe) |-> pin_io_cell_oe == mc_oe[PIN_COUNT-1:0])
        else $error("pin enable differs from cell enable");
    a_reset_quiet: assert property ($rose(presetn) |-> mc_out == 18'h0 && mc_oe == 18'h0)
        else $error("outputs not clear after reset");
    // Main scenarios seen
    c_refused: cover property (pslverr);
    c_write: cover property (pready && pwrite);
    c_toggle: cover property ($rose(mc_out[3]));
    c_set: cover property ($rose(mc_out[4]));
endmodule // logic_cluster_chk
bind logic_cluster logic_cluster_chk #(.PIN_COUNT(PIN_COUNT)) u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mc_out(mc_out), .mc_oe(mc_oe), .pin_io_cell_out(pin_io_cell_out),
    .pin_io_cell_oe(pin_io_cell_oe));
`default_nettype wire

// ==== testbench/logic_cluster_tb.sv ====
// Purpose: Self-checking bench for the logic cluster over APB.
// Assumes: Fewest bonded outputs (12) to check the pin subset.
// Notes:   Waits of six edges cover matrix, sync, cell and output registers.
`timescale 1ns/1ps
`default_nettype none
module logic_cluster_tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er;
    logic [35:0] want_in = 36'h0, routed_in;
    logic [2:0]  want_clk = 3'h0, global_clock_pin;
    logic        want_gsr = 1'b0, global_set_reset_line;
    logic [17:0] mc_out, mc_oe;
    logic [11:0] pin_io_cell_out, pin_io_cell_oe;
    int          err_count = 0, cmp_count = 0, cyc = 0;
    always #12.5 pclk = ~pclk;
    logic_cluster #(.PIN_COUNT(12), .HAS_LOCAL_FB(1'b1)) u_dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .routed_in(routed_in),
        .global_clock_pin(global_clock_pin), .global_set_reset_line(global_set_reset_line),
        .mc_out(mc_out), .mc_oe(mc_oe), .pin_io_cell_out(pin_io_cell_out),
        .pin_io_cell_oe(pin_io_cell_oe));
    matrix_model u_mx (.pclk(pclk), .want_in(want_in), .want_clk(want_clk), .want_gsr(want_gsr),
        .routed_in(routed_in), .global_clock_pin(global_clock_pin),
        .global_set_reset_line(global_set_reset_line));
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input int a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= 14'(a); pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Term p picks one array column; optionally summed into cell m
    task automatic cfg(input int m, input logic [31:0] c, input int p, input int col,
                       input bit al);
        apb(1'b1, 'h1000 + p * 16 + (col / 32) * 4, 32'h1 << (col % 32));
        if (al) apb(1'b1, 'h2000 + m * 16 + 4 + (p / 32) * 4, 32'h1 << (p % 32));
        apb(1'b1, 'h2000 + m * 16, c);
    endtask
    task automatic expect_out(input logic [17:0] e, input string what);
        repeat (6) @(posedge pclk);
        chk({14'h0, mc_out}, {14'h0, e}, what);
        chk({20'h0, pin_io_cell_out}, {20'h0, e[11:0]}, "pin copy");
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        expect_out(18'h0, "after reset");
        apb(1'b0, 'h0, 32'h0);
        chk(rd, 32'h0, "run default");
        apb(1'b1, 'h3000, 32'hffff_ffff);
        chk({31'h0, er}, 32'h1, "unmapped refused");
        chk(rd, 32'h0, "unmapped data");
        cfg(0, 32'h200, 0, 0, 1'b1);
        cfg(1, 32'h0, 5, 37, 1'b1);
        cfg(2, 32'h105, 10, 2, 1'b1);
        cfg(3, 32'h2a, 15, 0, 1'b1);
        cfg(4, 32'h41, 22, 3, 1'b0);
        cfg(5, 32'h1000, 25, 72, 1'b1);
        apb(1'b1, 'h0, 32'h1);
        expect_out(18'h26, "preload and complement");
        chk({14'h0, mc_oe}, 32'h1, "enables");
        chk({20'h0, pin_io_cell_oe}, 32'h1, "pin enables");
        want_in <= 36'h1;
        expect_out(18'h7, "true input");
        apb(1'b0, 'h4, 32'h0);
        chk(rd, 32'h7, "status read");
        want_clk <= 3'h3;
        expect_out(18'h3, "D capture, no toggle on rise");
        want_clk <= 3'h0;
        expect_out(18'hb, "toggle on inverted edge");
        want_gsr <= 1'b1;
        expect_out(18'hf, "global set/reset");
        want_gsr <= 1'b0;
        want_in <= 36'h9;
        expect_out(18'h1f, "set without clock");
        test_done();
    end
endmodule // logic_cluster_tb
`default_nettype wire

// ==== testbench/matrix_model.sv ====
// Purpose: Routing matrix and global pin side seen by the cluster.
// Assumes: Requests come from the bench, launched after a pclk edge.
// Notes:   Levels only; clock pins stay put unless a pulse is asked for.
`timescale 1ns/1ps
`default_nettype none
module matrix_model (
    input  wire logic        pclk,
    input  wire logic [35:0] want_in,
    input  wire logic [2:0]  want_clk,
    input  wire logic        want_gsr,
    output var  logic [35:0] routed_in,
    output var  logic [2:0]  global_clock_pin,
    output var  logic        global_set_reset_line
);
    // Registered drive, as a real matrix adds its own delay
    always_ff @(posedge pclk) begin
        routed_in             <= want_in;
        global_clock_pin      <= want_clk;
        global_set_reset_line <= want_gsr;
    end
endmodule // matrix_model
`default_nettype wire
